// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, cnt_ok;
    logic chan0_pin_out, chan0_pin_oe, chan1_pin_out, chan1_pin_oe, timer_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, c1;
    int num_errors, check_count, hi, per;

    tpc_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan0_pin_out(chan0_pin_out), .chan0_pin_oe(chan0_pin_oe), .chan1_pin_out(chan1_pin_out),
        .chan1_pin_oe(chan1_pin_oe), .timer_irq(timer_irq));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ========================================
    // Shared tasks
    task finish_test;
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task meas;
        while (chan0_pin_out !== 1'b0) @(posedge pclk);
        while (chan0_pin_out !== 1'b1) @(posedge pclk);
        hi = 0;
        while (chan0_pin_out === 1'b1) begin
            @(posedge pclk);
            hi++;
        end
        per = hi;
        while (chan0_pin_out === 1'b0) begin
            @(posedge pclk);
            per++;
        end
    endtask
    task hold(input logic v);
        repeat (20) @(posedge pclk);
        repeat (32) begin
            @(posedge pclk);
            chk(chan0_pin_out, v);
        end
    endtask
    task setup(input logic [31:0] v, input logic [31:0] c);
        bus(1'b1, tpc_pkg::TIMER_SC_OFS, 32'h30);
        bus(1'b1, tpc_pkg::MODULO_OFS, 32'h0F);
        bus(1'b1, tpc_pkg::CHAN0_VAL_OFS, v);
        bus(1'b1, tpc_pkg::CHAN0_SC_OFS, c);
        bus(1'b1, tpc_pkg::TIMER_SC_OFS, 32'h40);
    endtask
    // ========================================
    // Scenarios
    task t_reset;
        bus(1'b0, tpc_pkg::TIMER_SC_OFS, 32'h0);
        chk(rd, 32'h20);
        bus(1'b0, tpc_pkg::MODULO_OFS, 32'h0);
        chk(rd, 32'hFFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        bus(1'b1, tpc_pkg::COUNTER_OFS, 32'h55);
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_halt;
        bus(1'b1, tpc_pkg::TIMER_SC_OFS, 32'h0);
        repeat (20) @(posedge pclk);
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        c1 = rd;
        @(posedge pclk);
        ce <= 1'b0;
        repeat (10) @(posedge pclk);
        ce <= 1'b1;
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        chk(rd, c1 + 32'h4);
        bus(1'b1, tpc_pkg::TIMER_SC_OFS, 32'h20);
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        c1 = rd;
        cnt_ok = (c1 > 32'h10);
        chk(cnt_ok, 1'b1);
        repeat (10) @(posedge pclk);
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        chk(rd, c1);
        bus(1'b1, tpc_pkg::TIMER_SC_OFS, 32'h30);
        bus(1'b0, tpc_pkg::COUNTER_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_pwm;
        setup(32'h4, 32'h5A);
        meas;
        chk(hi, 4);
        chk(per, 16);
        chk(timer_irq, 1'b1);
        bus(1'b0, tpc_pkg::CHAN0_SC_OFS, 32'h0);
        chk(rd[7], 1'b1);
        bus(1'b0, tpc_pkg::TIMER_SC_OFS, 32'h0);
        chk(rd[7], 1'b1);
        bus(1'b1, tpc_pkg::CHAN0_VAL_OFS, 32'h0);
        hold(1'b0);
    endtask
    task t_duty;
        bus(1'b1, tpc_pkg::CHAN0_VAL_OFS, 32'h4);
        bus(1'b1, tpc_pkg::CHAN0_SC_OFS, 32'h18);
        hold(1'b0);
        bus(1'b1, tpc_pkg::CHAN0_SC_OFS, 32'h19);
        hold(1'b1);
    endtask
    task t_link;
        setup(32'h4, 32'h3A);
        bus(1'b1, tpc_pkg::CHAN1_SC_OFS, 32'h1E);
        chk(chan1_pin_oe, 1'b0);
        meas;
        chk(hi, 4);
        bus(1'b1, tpc_pkg::CHAN1_VAL_OFS, 32'h8);
        meas;
        chk(hi, 8);
        bus(1'b1, tpc_pkg::CHAN0_VAL_OFS, 32'h6);
        meas;
        chk(hi, 6);
        chk(chan1_pin_oe, 1'b0);
        bus(1'b1, tpc_pkg::CHAN0_SC_OFS, 32'h1A);
        repeat (40) @(posedge pclk);
        chk(chan1_pin_oe, 1'b1);
        hi = 0;
        repeat (16) begin
            @(posedge pclk);
            if (chan1_pin_out === 1'b1) begin
                hi++;
            end
        end
        chk(hi, 8);
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        finish_test;
    end
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        check_count = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_halt;
        t_pwm;
        t_duty;
        t_link;
        finish_test;
    end
endmodule

// ### bench/tpc_chk.sv
`timescale 1ns/1ps
// ========================================
// Port checker
module tpc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan0_pin_out,
    input wire logic chan0_pin_oe,
    input wire logic chan1_pin_out,
    input wire logic chan1_pin_oe,
    input wire logic timer_irq
);
    logic [7:0] sh0_reg, sh0_next;
    logic [1:0] ie_reg, ie_next;
    logic st0_reg, st0_next;
    logic wr_s, ie_any, mode_on;
    assign wr_s = psel && penable && pready && pwrite && ce;
    assign ie_any = (|ie_reg) || sh0_reg[6];
    assign mode_on = st0_reg && (sh0_reg[5] || sh0_reg[4]);
    // ========================================
    // Shadow of written controls
    always_comb begin
        sh0_next = sh0_reg;
        ie_next = ie_reg;
        st0_next = 1'b1;
        if (wr_s && paddr == tpc_pkg::CHAN0_SC_OFS) begin
            sh0_next = pwdata[7:0];
            st0_next = 1'b0;
        end
        if (wr_s && paddr == tpc_pkg::TIMER_SC_OFS) begin
            ie_next[0] = pwdata[6];
        end
        if (wr_s && paddr == tpc_pkg::CHAN1_SC_OFS) begin
            ie_next[1] = pwdata[6];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh0_reg <= 8'h00;
            ie_reg <= 2'h0;
            st0_reg <= 1'b1;
        end else begin
            sh0_reg <= sh0_next;
            ie_reg <= ie_next;
            st0_reg <= st0_next;
        end
    end
    // ========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    a_ready_once: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_only: assert property (pready |-> psel && penable && !$past(pready)) else $error("stray ready");
    a_err_map: assert property (pready && paddr > 8'h18 |-> pslverr) else $error("unmapped not refused");
    a_pin_drive: assert property (mode_on && sh0_reg[3:2] != 2'h0 |-> chan0_pin_oe)
        else $error("pin 0 not driven");
    a_link_free: assert property (st0_reg && sh0_reg[5] |-> !chan1_pin_oe)
        else $error("pin 1 driven while linked");
    a_zero_duty: assert property (mode_on && sh0_reg[3:0] == 4'h8 |-> !$rose(chan0_pin_out))
        else $error("pin rose without overflow toggle");
    a_full_duty: assert property (mode_on && sh0_reg[3] && sh0_reg[1:0] == 2'h1 |-> chan0_pin_out == !sh0_reg[2])
        else $error("full duty not held");
    a_irq_gate: assert property (!ie_any && !$past(ie_any) |-> !timer_irq)
        else $error("irq without enable");
endmodule

bind tpc_top tpc_chk chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan0_pin_out(chan0_pin_out), .chan0_pin_oe(chan0_pin_oe), .chan1_pin_out(chan1_pin_out),
    .chan1_pin_oe(chan1_pin_oe), .timer_irq(timer_irq));

// ### design/tpc_pkg.sv
// What this block does
// R1 - On counter match, drive channel pin high, low or inverted per compare action.
// R2 - Unbuffered value writes act at once; passed values miss that period.
// R3 - Software writes smaller values in compare handler, larger in overflow handler.
// R4 - Channel 0 link bit pairs channels; combined output only on channel 0 pin.
// R5 - Linked: channel 0 value first; last written pair takes over at overflow.
// R6 - Linked: channel 0 control governs, channel 1 control ignored, pin 1 released.
// R7 - Linked: write to active value register acts immediately.
// R8 - Toggle at overflow flips pin when counter reaches modulo; period between overflows.
// R9 - Software sets compare action to the complement of the active pulse level.
// R10 - PWM period equals modulo plus one counter clocks.
// R11 - Software avoids toggle compare action while generating PWM.
// R12 - Software halts and clears counter, programs modulo, value, mode, then releases.
// R13 - Halt bit stops counter; clear bit zeroes counter and prescaler.
// R14 - Mode 0:1 selects unbuffered, 1:0 selects linked buffered operation.
// R15 - Compare action 1:0 drives pin low, 1:1 drives pin high.
// R16 - Channel 0 upper mode bit overrides lower mode bit.
// R17 - Without overflow toggle, pin never toggles at overflow, giving zero duty.
// R18 - Full duty bit with overflow toggle clear holds output at full duty.
// R19 - Compare sets channel event flag; interrupt only when channel enable set.
// R20 - Rollover after modulo match sets overflow flag; interrupt when enabled.
// R21 - Compare is full 16-bit equality, once per counter increment.
// R22 - Compare action level wins over coincident overflow toggle.
package tpc_pkg;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] TIMER_SC_OFS = 8'h00;
    localparam logic [7:0] COUNTER_OFS = 8'h04;
    localparam logic [7:0] MODULO_OFS = 8'h08;
    localparam logic [7:0] CHAN0_SC_OFS = 8'h0C;
    localparam logic [7:0] CHAN0_VAL_OFS = 8'h10;
    localparam logic [7:0] CHAN1_SC_OFS = 8'h14;
    localparam logic [7:0] CHAN1_VAL_OFS = 8'h18;

    // ========================================
    // Timer status and control fields
    localparam int OVF_FLAG_BIT = 7;
    localparam int OVF_IE_BIT = 6;
    localparam int HALT_BIT = 5;
    localparam int CLEAR_BIT = 4;
    localparam int PS_LSB = 0;
    localparam int PS_W = 3;
    localparam logic [2:0] PS_EXTERNAL = 3'h7;
    localparam int PRESC_W = 6;

    // ========================================
    // Channel status and control fields
    localparam int CH_FLAG_BIT = 7;
    localparam int CH_IE_BIT = 6;
    localparam int MS_UPPER_BIT = 5;
    localparam int MS_LOWER_BIT = 4;
    localparam int ACT_UPPER_BIT = 3;
    localparam int ACT_LOWER_BIT = 2;
    localparam int TOV_BIT = 1;
    localparam int MAX_BIT = 0;

    // ========================================
    // Reset values
    localparam logic [15:0] MODULO_RESET = 16'hFFFF;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [7:0] CH_SC_RESET = 8'h00;

endpackage

// ### design/tpc_top.sv
`timescale 1ns/1ps
module tpc_top #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chan0_pin_out,
    output logic chan0_pin_oe,
    output logic chan1_pin_out,
    output logic chan1_pin_oe,
    output logic timer_irq
);

    // ========================================
    // Helpers
    function automatic logic [tpc_pkg::PRESC_W-1:0] presc_mask(input logic [2:0] ps);
        logic [tpc_pkg::PRESC_W-1:0] m;
        m = '0;
        for (int k = 0; k < tpc_pkg::PRESC_W; k++) begin
            if (k < int'(ps)) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic out_mode(input logic [7:0] sc);
        return sc[tpc_pkg::ACT_UPPER_BIT] | sc[tpc_pkg::ACT_LOWER_BIT];
    endfunction

    // ========================================
    // State
    logic [7:0] tsc_reg, tsc_next;
    logic ovf_arm_reg, ovf_arm_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] mod_reg, mod_next;
    logic [tpc_pkg::PRESC_W-1:0] presc_reg, presc_next;
    logic [7:0] sc_reg [2];
    logic [7:0] sc_next [2];
    logic [CNT_W-1:0] val_reg [2];
    logic [CNT_W-1:0] val_next [2];
    logic [1:0] arm_reg, arm_next;
    logic [1:0] pin_reg, pin_next;
    logic [1:0] oe_reg, oe_next;
    logic active_reg, active_next;
    logic pending_reg, pending_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;

    // ========================================
    // Bus decode
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic linked;
    logic ovf_ev;
    logic [1:0] cmp_ev;
    logic [CNT_W-1:0] cmp_val [2];

    assign wr_en = psel & penable & pwrite & pready_reg;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign linked = sc_reg[0][tpc_pkg::MS_UPPER_BIT]; // R4 R16

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            tpc_pkg::TIMER_SC_OFS,
            tpc_pkg::COUNTER_OFS,
            tpc_pkg::MODULO_OFS,
            tpc_pkg::CHAN0_SC_OFS,
            tpc_pkg::CHAN0_VAL_OFS,
            tpc_pkg::CHAN1_SC_OFS,
            tpc_pkg::CHAN1_VAL_OFS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ========================================
    // Bus answer
    always_comb begin
        prdata_next = prdata_reg;
        pready_next = psel & ~penable;
        pslverr_next = psel & ~penable & ~mapped;
        if (rd_setup) begin
            prdata_next = '0;
            case (paddr)
                tpc_pkg::TIMER_SC_OFS: begin
                    prdata_next[7:0] = tsc_reg & ~(8'h01 << tpc_pkg::CLEAR_BIT);
                end
                tpc_pkg::COUNTER_OFS: begin
                    prdata_next[CNT_W-1:0] = cnt_reg;
                end
                tpc_pkg::MODULO_OFS: begin
                    prdata_next[CNT_W-1:0] = mod_reg;
                end
                tpc_pkg::CHAN0_SC_OFS: begin
                    prdata_next[7:0] = sc_reg[0];
                end
                tpc_pkg::CHAN0_VAL_OFS: begin
                    prdata_next[CNT_W-1:0] = val_reg[0];
                end
                tpc_pkg::CHAN1_SC_OFS: begin
                    prdata_next[7:0] = sc_reg[1] & ~(8'h01 << tpc_pkg::MS_UPPER_BIT);
                end
                tpc_pkg::CHAN1_VAL_OFS: begin
                    prdata_next[CNT_W-1:0] = val_reg[1];
                end
                default: begin
                    prdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ========================================
    // Counter, prescaler and timer control
    always_comb begin
        tsc_next = tsc_reg;
        tsc_next[tpc_pkg::CLEAR_BIT] = 1'b0;
        ovf_arm_next = ovf_arm_reg;
        cnt_next = cnt_reg;
        mod_next = mod_reg;
        presc_next = presc_reg;
        ovf_ev = 1'b0;
        if (rd_setup && paddr == tpc_pkg::TIMER_SC_OFS && tsc_reg[tpc_pkg::OVF_FLAG_BIT]) begin
            ovf_arm_next = 1'b1;
        end
        if (tsc_reg[tpc_pkg::CLEAR_BIT]) begin
            cnt_next = '0; // R13
            presc_next = '0; // R13
        end else if (!tsc_reg[tpc_pkg::HALT_BIT] &&
                     tsc_reg[tpc_pkg::PS_LSB +: tpc_pkg::PS_W] != tpc_pkg::PS_EXTERNAL) begin // R13
            presc_next = presc_reg + 1'b1;
            if ((presc_reg & presc_mask(tsc_reg[tpc_pkg::PS_LSB +: tpc_pkg::PS_W])) ==
                presc_mask(tsc_reg[tpc_pkg::PS_LSB +: tpc_pkg::PS_W])) begin
                if (cnt_reg == mod_reg) begin
                    cnt_next = '0; // R10
                    ovf_ev = 1'b1; // R20
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
                if (presc_next == (presc_mask(tsc_reg[tpc_pkg::PS_LSB +: tpc_pkg::PS_W]) + 1'b1) ||
                    tsc_reg[tpc_pkg::PS_LSB +: tpc_pkg::PS_W] == 3'h0) begin
                    presc_next = '0;
                end
            end
        end
        if (wr_en && paddr == tpc_pkg::TIMER_SC_OFS) begin
            tsc_next[tpc_pkg::OVF_IE_BIT] = pwdata[tpc_pkg::OVF_IE_BIT];
            tsc_next[tpc_pkg::HALT_BIT] = pwdata[tpc_pkg::HALT_BIT];
            tsc_next[tpc_pkg::CLEAR_BIT] = pwdata[tpc_pkg::CLEAR_BIT];
            tsc_next[tpc_pkg::PS_LSB +: tpc_pkg::PS_W] = pwdata[tpc_pkg::PS_LSB +: tpc_pkg::PS_W];
            if (!pwdata[tpc_pkg::OVF_FLAG_BIT] && ovf_arm_reg) begin
                tsc_next[tpc_pkg::OVF_FLAG_BIT] = 1'b0;
            end
            ovf_arm_next = 1'b0;
        end
        if (wr_en && paddr == tpc_pkg::MODULO_OFS) begin
            mod_next = pwdata[CNT_W-1:0];
        end
        if (ovf_ev) begin
            tsc_next[tpc_pkg::OVF_FLAG_BIT] = 1'b1; // R20
            ovf_arm_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsc_reg <= 8'h01 << tpc_pkg::HALT_BIT;
            ovf_arm_reg <= 1'b0;
            cnt_reg <= '0;
            mod_reg <= tpc_pkg::MODULO_RESET[CNT_W-1:0];
            presc_reg <= '0;
        end else if (ce) begin
            tsc_reg <= tsc_next;
            ovf_arm_reg <= ovf_arm_next;
            cnt_reg <= cnt_next;
            mod_reg <= mod_next;
            presc_reg <= presc_next;
        end
    end

    // ========================================
    // Channels: compare, pins, flags, link
    always_comb begin
        cmp_val[0] = (linked && active_reg) ? val_reg[1] : val_reg[0]; // R5 R7
        cmp_val[1] = val_reg[1];
        cmp_ev = '0;
        for (int i = 0; i < 2; i++) begin
            if (cnt_next != cnt_reg && cnt_next == cmp_val[i] && !(i == 1 && linked)) begin // R6
                cmp_ev[i] = 1'b1; // R21 R2
            end
        end
    end

    always_comb begin
        active_next = active_reg;
        pending_next = pending_reg;
        arm_next = arm_reg;
        pin_next = pin_reg;
        oe_next = oe_reg;
        for (int i = 0; i < 2; i++) begin
            sc_next[i] = sc_reg[i];
            val_next[i] = val_reg[i];
        end
        if (!linked) begin
            active_next = 1'b0; // R5
            pending_next = 1'b0;
        end else if (ovf_ev) begin
            active_next = pending_reg; // R5
        end
        for (int i = 0; i < 2; i++) begin
            oe_next[i] = out_mode(sc_reg[i]) && !(i == 1 && linked); // R4 R6
            if (out_mode(sc_reg[i]) && !(i == 1 && linked)) begin
                if (sc_reg[i][tpc_pkg::MAX_BIT] && !sc_reg[i][tpc_pkg::TOV_BIT]) begin
                    pin_next[i] = ~sc_reg[i][tpc_pkg::ACT_LOWER_BIT]; // R18
                end else begin
                    if (ovf_ev && sc_reg[i][tpc_pkg::TOV_BIT]) begin
                        pin_next[i] = ~pin_reg[i]; // R8 R17
                    end
                    if (cmp_ev[i]) begin
                        case (sc_reg[i][tpc_pkg::ACT_UPPER_BIT -: 2])
                            2'h1: pin_next[i] = ~pin_reg[i]; // R1
                            2'h2: pin_next[i] = 1'b0; // R1 R15 R22
                            2'h3: pin_next[i] = 1'b1; // R1 R15 R22
                            default: pin_next[i] = pin_reg[i];
                        endcase
                    end
                end
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (rd_setup && sc_reg[i][tpc_pkg::CH_FLAG_BIT] &&
                paddr == (i == 0 ? tpc_pkg::CHAN0_SC_OFS : tpc_pkg::CHAN1_SC_OFS)) begin
                arm_next[i] = 1'b1;
            end
            if (wr_en && paddr == (i == 0 ? tpc_pkg::CHAN0_SC_OFS : tpc_pkg::CHAN1_SC_OFS)) begin
                sc_next[i][6:0] = pwdata[6:0]; // R14 R16
                if (i == 1) begin
                    sc_next[i][tpc_pkg::MS_UPPER_BIT] = 1'b0;
                end
                if (!pwdata[tpc_pkg::CH_FLAG_BIT] && arm_reg[i]) begin
                    sc_next[i][tpc_pkg::CH_FLAG_BIT] = 1'b0;
                end
                arm_next[i] = 1'b0;
            end
            if (wr_en && paddr == (i == 0 ? tpc_pkg::CHAN0_VAL_OFS : tpc_pkg::CHAN1_VAL_OFS)) begin
                val_next[i] = pwdata[CNT_W-1:0]; // R2 R7
                pending_next = (i == 1); // R5
            end
        end
        if (cmp_ev[0]) begin
            sc_next[0][tpc_pkg::CH_FLAG_BIT] = 1'b1; // R19
        end
        if (cmp_ev[1]) begin
            sc_next[1][tpc_pkg::CH_FLAG_BIT] = 1'b1; // R19
        end
        irq_next = (tsc_reg[tpc_pkg::OVF_FLAG_BIT] & tsc_reg[tpc_pkg::OVF_IE_BIT]) | // R20
                   (sc_reg[0][tpc_pkg::CH_FLAG_BIT] & sc_reg[0][tpc_pkg::CH_IE_BIT]) | // R19
                   (sc_reg[1][tpc_pkg::CH_FLAG_BIT] & sc_reg[1][tpc_pkg::CH_IE_BIT] & ~linked); // R6
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                sc_reg[i] <= tpc_pkg::CH_SC_RESET;
                val_reg[i] <= tpc_pkg::VALUE_RESET[CNT_W-1:0];
            end
            active_reg <= 1'b0;
            pending_reg <= 1'b0;
            arm_reg <= '0;
            pin_reg <= '0;
            oe_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                sc_reg[i] <= sc_next[i];
                val_reg[i] <= val_next[i];
            end
            active_reg <= active_next;
            pending_reg <= pending_next;
            arm_reg <= arm_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            irq_reg <= irq_next;
        end
    end

    // ========================================
    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign chan0_pin_out = pin_reg[0];
    assign chan0_pin_oe = oe_reg[0];
    assign chan1_pin_out = pin_reg[1];
    assign chan1_pin_oe = oe_reg[1];
    assign timer_irq = irq_reg;

endmodule
